// >>> src/bcd_datapath.sv
/*
  bit-count / conditional-op / divide-helper execution datapath with an
  apb slave for control and status.
  assumes decode presents register values in bcd_req_t and writeback
  takes bcd_res_t one cycle later; all on clock_i.
  limitation: the divide step itself is not here; setup and
  adjust only bracket an iterative divide done elsewhere.
  a request made while disabled is dropped, not held.
*/
// Chosen here: the register addresses and the APB slave port.
//
// Notes on behaviour
// - word sign count: bits below 31 equal 31
// - halfword sign count per 16-bit half
// - word zero count from bit 31, 32 max
// - halfword zero count per half
// - move when implicit register non-zero
// - move when implicit register is zero
// - subtract when condition non-zero else pass
// - subtract when condition zero else pass
// - subtract flags change only when subtracting
// - extract bits 63:32 of shifted pair
// - same or different source registers both work
// - adjust quotient low, remainder high word
// - exact negative division: zero remainder, bump quotient
// - ones-complement negatives become twos-complement
// - divide ops update overflow and sticky overflow
// - setup extends dividend to 64 and shifts
// - shift 0 word, 16 half, 24 byte
// - vacated bits take quotient sign
// - overflow when remainder magnitude reaches divisor

`timescale 1ns/1ps

module bcd_datapath (
  // clock and reset
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  // operation request from decode
  input  wire bcd_pkg::bcd_req_t   req_i,
  // result and flags to writeback
  output logic                     [0:0] unused_o_dummy_never,
  output bcd_pkg::bcd_res_t        res_o,
  output bcd_pkg::bcd_flags_t      flags_o,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o
);
  import bcd_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // registered answer, flags and bus state
  bcd_res_t   res_reg,   res_next;
  bcd_flags_t flags_reg, flags_next;
  logic       enable_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // flag update strobes from the result mux
  logic        upd_v, upd_av, v_new, av_new;
  logic        take;
  logic        apb_wr;
  logic [3:0]  status_clr;
  logic        addr_ok;

  // spare output, tied low
  assign unused_o_dummy_never = 1'b0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zeros above the first one; all callers but the word zero count pad so a one always exists below
  // one loop serves every width; it flattens to a priority encoder
  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] n;
    logic       hit;
    n   = 6'h00;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        hit = 1'b1;
      end else if (!hit) begin
        n = n + 6'h01;
      end
    end
    return n;
  endfunction

  // short move immediate, sign-extended
  function automatic logic [31:0] sext4(input logic [3:0] v);
    return {{28{v[3]}}, v};
  endfunction

  // magnitude of a signed word, 33 bits so that the most negative fits
  function automatic logic [32:0] mag(input logic [31:0] v);
    return v[31] ? (33'h0 - {v[31], v}) : {1'b0, v};
  endfunction

  // ----------------------------------------------------------------
  // operation datapath
  // ----------------------------------------------------------------
  logic [32:0] diff;
  logic        sub_ofl;
  logic [63:0] pair_shift;
  logic [4:0]  pos;
  logic [63:0] ext;
  logic [63:0] fill;
  logic [63:0] setup;
  logic [5:0]  shamt;
  logic        sgn;
  logic        qsign;
  logic        rem_neg, quo_neg;
  logic [31:0] rem_mag, quo_mag;
  logic [5:0]  half_sign [2];
  logic [5:0]  half_zero [2];

  // requests count only while enabled
  assign take = req_i.valid & enable_reg;

  // shared subtractor; overflow when operand signs differ and result flips
  // the extra bit keeps the borrow out of the sign
  assign diff    = {req_i.opa[31], req_i.opa} - {req_i.opb[31], req_i.opb};
  assign sub_ofl = (req_i.opa[31] != req_i.opb[31]) && (diff[31] != req_i.opa[31]);

  // pair treated as one 64-bit value, so aliased sources need no special path
  // only the low five position bits count
  assign pos        = req_i.use_imm ? req_i.imm_pos : req_i.cond[4:0];
  assign pair_shift = {req_i.opa, req_i.opb} << pos;

  // divide setup: extend, shift, fill with the expected quotient sign
  // shift amount follows the expected quotient size
  always_comb begin
    case (req_i.op)
      op_div_setup_half, divide_setup_half_unsigned: shamt = SHIFT_HALF;
      op_div_setup_byte, divide_setup_byte_unsigned: shamt = SHIFT_BYTE;
      default:                                       shamt = SHIFT_WORD;
    endcase
  end

  // unsigned forms never fill: their quotient sign is zero
  assign sgn   = (req_i.op == op_div_setup_word) || (req_i.op == op_div_setup_half) ||
                 (req_i.op == op_div_setup_byte);
  // signed forms sign-extend, unsigned ones zero-extend
  assign ext   = {{32{sgn & req_i.opa[31]}}, req_i.opa};
  assign qsign = sgn & (req_i.opa[31] ^ req_i.opb[31]);
  // the fill replaces leading steps that only copy the sign
  assign fill  = (64'h1 << shamt) - 64'h1;
  assign setup = (ext << shamt) | (qsign ? fill : 64'h0);

  // divide adjust: remainder sign follows the original dividend
  // negatives arrive in ones-complement; inverting gives the
  // magnitude, negating that later gives twos-complement
  assign rem_neg = req_i.cond[31];
  assign quo_neg = req_i.opa[31];
  assign rem_mag = rem_neg ? ~req_i.cond : req_i.cond;
  assign quo_mag = quo_neg ? ~req_i.opa  : req_i.opa;

  // one count pair per half; the pad stops each count at the half boundary
  for (genvar g = 0; g < 2; g++) begin : g_half
    assign half_sign[g] = lead_zeros({req_i.opa[16*g+14 -: 15] ^ {15{req_i.opa[16*g+15]}}, 17'h1ffff});
    assign half_zero[g] = lead_zeros({req_i.opa[16*g+15 -: 16], 16'hffff});
  end

  // ----------------------------------------------------------------
  // result selection
  // ----------------------------------------------------------------
  always_comb begin
    logic [32:0] bmag;
    logic [31:0] rm, qm;
    bmag     = mag(req_i.opb);
    rm       = rem_mag;
    qm       = quo_mag;
    res_next = '0;
    upd_v    = 1'b0;
    upd_av   = 1'b0;
    v_new    = 1'b0;
    av_new   = 1'b0;
    res_next.valid = take;
    res_next.wr_en = take;
    // counts are zero-extended into their word or half
    case (req_i.op)
      op_lead_sign: begin
        res_next.lo = {26'h0, lead_zeros({req_i.opa[30:0] ^ {31{req_i.opa[31]}}, 1'b1})};
      end
      op_lead_sign_half: begin
        res_next.lo = {11'h0, half_sign[1][4:0], 11'h0, half_sign[0][4:0]};
      end
      op_lead_zero: begin
        res_next.lo = {26'h0, lead_zeros(req_i.opa)};
      end
      op_lead_zero_half: begin
        res_next.lo[31:16] = {10'h0, half_zero[1]};
        res_next.lo[15:0]  = {10'h0, half_zero[0]};
      end
      op_cond_move, op_cond_move_not: begin
        // no write at all when the condition fails, destination keeps its value
        res_next.lo    = req_i.use_imm ? sext4(req_i.imm_four_bit) : req_i.opb;
        res_next.wr_en = take & ((req_i.op == op_cond_move) ? (req_i.cond != 32'h0)
                                                            : (req_i.cond == 32'h0));
      end
      op_cond_sub, op_cond_sub_not: begin
        // a skipped subtraction passes opa and keeps every flag
        upd_v  = (req_i.op == op_cond_sub) ? (req_i.cond != 32'h0)
                                           : (req_i.cond == 32'h0);
        upd_av = upd_v;
        res_next.lo = upd_v ? diff[31:0] : req_i.opa;
        v_new  = sub_ofl;
        av_new = diff[31] ^ diff[30];
      end
      op_dbl_extract: begin
        // top word of the shifted pair
        res_next.lo = pair_shift[63:32];
      end
      op_div_adjust: begin
        // exact negative division leaves the remainder a divisor too large
        if (rem_neg && ({1'b0, rm} == bmag)) begin
          rm = 32'h0;
          qm = qm + 32'h1;
        end
        res_next.pair = 1'b1;
        // quotient to lo, remainder to hi
        res_next.lo   = quo_neg ? (32'h0 - qm) : qm;
        res_next.hi   = rem_neg ? (32'h0 - rm) : rm;
        upd_v = 1'b1;
        // a zero divisor gives no valid quotient
        v_new = (req_i.opb == 32'h0);
      end
      default: begin
        // the six divide setup forms
        res_next.pair = 1'b1;
        res_next.lo   = setup[31:0];
        res_next.hi   = setup[63:32];
        upd_v = 1'b1;
        v_new = sgn ? (mag(setup[63:32]) >= bmag)
                    : ({1'b0, setup[63:32]} >= {1'b0, req_i.opb});
      end
    endcase
  end

  // ----------------------------------------------------------------
  // status flags: hardware set beats a software clear in the same cycle
  // ----------------------------------------------------------------
  // ofl and advance ofl follow the last updating operation;
  // sticky copies gather until software writes ones
  always_comb begin
    flags_next = flags_reg;
    if (take && upd_v) begin
      flags_next.ofl_flag = v_new;
    end
    if (take && upd_av) begin
      flags_next.advance_ofl_flag = av_new;
    end
    flags_next.sticky_ofl_flag = (flags_reg.sticky_ofl_flag & ~status_clr[ST_SOFL_BIT]) |
                                 (take & upd_v & v_new);
    flags_next.sticky_advance_ofl_flag =
      (flags_reg.sticky_advance_ofl_flag & ~status_clr[ST_SAOFL_BIT]) |
      (take & upd_av & av_new);
  end

  // result register feeding writeback
  // valid and wr_en mark real results; data is rebuilt each cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  // flag register
  // flags reset clear so no stale overflow survives
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase, pready raised from setup
  // ----------------------------------------------------------------
  // unmapped offsets answer with an error and read zero
  assign addr_ok = (paddr_i == REG_CTRL) || (paddr_i == REG_STATUS) ||
                   (paddr_i == REG_LAST_LO) || (paddr_i == REG_LAST_HI);
  assign apb_wr  = psel_i & penable_i & pready_reg & pwrite_i & addr_ok;
  // write one to a sticky bit clears it
  // ofl and advance ofl ignore software writes
  assign status_clr = (apb_wr && (paddr_i == REG_STATUS)) ? pwdata_i[3:0] : 4'h0;

  // control register: enable gates request acceptance
  // clearing enable drops requests; answers in flight still arrive
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_reg <= CTRL_EN_RST;
    end else if (apb_wr && (paddr_i == REG_CTRL)) begin
      enable_reg <= pwdata_i[CTRL_EN_BIT];
    end
  end

  // handshake and read data are captured in the setup cycle
  // no wait state: pready is high in the first access cycle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= psel_i & ~penable_i;
      pslverr_reg <= psel_i & ~penable_i & ~addr_ok;
      if (psel_i && !penable_i && !pwrite_i) begin
        case (paddr_i)
          REG_CTRL:    prdata_reg <= {31'h0, enable_reg};
          REG_STATUS:  prdata_reg <= {28'h0, flags_reg.sticky_advance_ofl_flag, flags_reg.advance_ofl_flag,
                                      flags_reg.sticky_ofl_flag, flags_reg.ofl_flag};
          REG_LAST_LO: prdata_reg <= res_reg.lo;
          REG_LAST_HI: prdata_reg <= res_reg.hi;
          default:     prdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // every output except the tied-low spare comes straight from a register
  assign res_o     = res_reg;
  assign flags_o   = flags_reg;
  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;

endmodule // bcd_datapath

// >>> src/bcd_pkg.sv
/*
  package for the bit-count, conditional-op and divide datapath:
  operation codes, carrier structs, register map and shift amounts.
  assumes the core's decode logic produces bcd_req_t once per cycle.
*/
package bcd_pkg;

  // ----------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_lead_sign               = 4'h0,
    op_lead_sign_half          = 4'h1,
    op_lead_zero               = 4'h2,
    op_lead_zero_half          = 4'h3,
    op_cond_move               = 4'h4,
    op_cond_move_not           = 4'h5,
    op_cond_sub                = 4'h6,
    op_cond_sub_not            = 4'h7,
    op_dbl_extract             = 4'h8,
    op_div_adjust              = 4'h9,
    op_div_setup_word          = 4'ha,
    op_div_setup_word_unsigned = 4'hb,
    op_div_setup_byte          = 4'hc,
    divide_setup_byte_unsigned = 4'hd,
    op_div_setup_half          = 4'he,
    divide_setup_half_unsigned = 4'hf
  } bcd_op_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;        // one-cycle request strobe
    bcd_op_t     op;
    logic [31:0] opa;          // first source / old destination / quotient word
    logic [31:0] opb;          // second source / divisor
    logic [31:0] cond;         // condition reg, position reg or remainder word
    logic [3:0]  imm_four_bit; // short immediate for conditional move
    logic [4:0]  imm_pos;      // immediate extract position
    logic        use_imm;      // take the immediate instead of a register
  } bcd_req_t;

  typedef struct packed {
    logic        valid;  // answer strobe
    logic        wr_en;  // destination must be written
    logic        pair;   // write hi as well (register pair)
    logic [31:0] lo;
    logic [31:0] hi;
  } bcd_res_t;

  typedef struct packed {
    logic ofl_flag;
    logic sticky_ofl_flag;
    logic advance_ofl_flag;
    logic sticky_advance_ofl_flag;
  } bcd_flags_t;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_STATUS  = 12'h004;
  localparam logic [11:0] REG_LAST_LO = 12'h008;
  localparam logic [11:0] REG_LAST_HI = 12'h00c;

  localparam int          CTRL_EN_BIT  = 0;
  localparam logic        CTRL_EN_RST  = 1'b1;
  localparam int          ST_OFL_BIT   = 0;
  localparam int          ST_SOFL_BIT  = 1;
  localparam int          ST_AOFL_BIT  = 2;
  localparam int          ST_SAOFL_BIT = 3;

  // ----------------------------------------------------------------
  // divide setup shift amounts
  // ----------------------------------------------------------------
  localparam logic [5:0] SHIFT_WORD = 6'h00;
  localparam logic [5:0] SHIFT_HALF = 6'h10;
  localparam logic [5:0] SHIFT_BYTE = 6'h18;

endpackage

// >>> tb/bcd_datapath_assertions.sv
/*
  concurrent checks on the datapath top ports, one request delayed a cycle.
  assumes it is bound to bcd_datapath and sees only its ports.
*/
`timescale 1ns/1ps
module bcd_datapath_assertions (
  // clock and reset
  input wire logic                clock_i,
  input wire logic                resetn_i,
  // operation side
  input wire bcd_pkg::bcd_req_t   req_i,
  input wire logic [0:0]          unused_o_dummy_never,
  input wire bcd_pkg::bcd_res_t   res_o,
  input wire bcd_pkg::bcd_flags_t flags_o,
  // apb side
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [11:0]         paddr_i,
  input wire logic [31:0]         pwdata_i,
  input wire logic [31:0]         prdata_o,
  input wire logic                pready_o,
  input wire logic                pslverr_o
);
  import bcd_pkg::*;
  bcd_req_t    q;
  logic [63:0] xs;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // request of the previous cycle, the cause of this cycle's answer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) q <= '0;
    else q <= req_i;
  end
  // shifted pair for the extract check
  assign xs = {q.opa, q.opb} << (q.use_imm ? q.imm_pos : q.cond[4:0]);
  a_sub_result: assert property (res_o.valid && q.op == op_cond_sub |->
    res_o.lo == ((q.cond != 0) ? q.opa - q.opb : q.opa)) else $error("cond sub result wrong");
  a_subn_result: assert property (res_o.valid && q.op == op_cond_sub_not |->
    res_o.lo == ((q.cond == 0) ? q.opa - q.opb : q.opa)) else $error("inverted sub result wrong");
  a_sub_flags: assert property (res_o.valid && q.op == op_cond_sub && q.cond == 0 |->
    flags_o == $past(flags_o)) else $error("flags moved on skipped sub");
  a_subn_flags: assert property (res_o.valid && q.op == op_cond_sub_not && q.cond != 0 |->
    flags_o == $past(flags_o)) else $error("flags moved on skipped inverted sub");
  a_move_write: assert property (res_o.valid && q.op == op_cond_move |-> res_o.wr_en == (q.cond != 0)
    && (!res_o.wr_en || res_o.lo == (q.use_imm ? {{28{q.imm_four_bit[3]}}, q.imm_four_bit} : q.opb)))
    else $error("cond move wrong");
  a_moven_write: assert property (res_o.valid && q.op == op_cond_move_not |-> res_o.wr_en == (q.cond == 0)
    && (!res_o.wr_en || res_o.lo == (q.use_imm ? {{28{q.imm_four_bit[3]}}, q.imm_four_bit} : q.opb)))
    else $error("inverted cond move wrong");
  a_extract_word: assert property (res_o.valid && q.op == op_dbl_extract |-> res_o.lo == xs[63:32])
    else $error("extract wrong");
  a_setup_unsigned: assert property (res_o.valid && q.op == op_div_setup_word_unsigned |->
    res_o.pair && {res_o.hi, res_o.lo} == {32'h0, q.opa} && flags_o.ofl_flag == (q.opb == 0))
    else $error("unsigned word setup wrong");
  a_adjust_flag: assert property (res_o.valid && q.op == op_div_adjust |->
    flags_o.ofl_flag == (q.opb == 0)) else $error("adjust overflow wrong");
  a_sticky_hold: assert property ($fell(flags_o.sticky_ofl_flag) |->
    $past(psel_i && penable_i && pwrite_i && paddr_i == REG_STATUS)) else $error("sticky lost");
  a_sticky_rise: assert property ($rose(flags_o.ofl_flag) |-> flags_o.sticky_ofl_flag)
    else $error("sticky not set");
  c_sub_ofl: cover property (res_o.valid && q.op == op_cond_sub && flags_o.ofl_flag);
  c_pair: cover property (res_o.valid && res_o.pair);
  c_slverr: cover property (pready_o && pslverr_o);
endmodule // bcd_datapath_assertions

// >>> tb/bcd_wb_model.sv
/*
  writeback model: one destination register fed from the result port.
  assumes results arrive as bcd_res_t on clock_i.
*/
`timescale 1ns/1ps
module bcd_wb_model (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  // result from the datapath
  input  wire bcd_pkg::bcd_res_t res_i,
  output logic [31:0]            dest_o
);
  import bcd_pkg::*;
  // a refused move leaves the old destination in place
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) dest_o <= 32'h0;
    else if (res_i.valid && res_i.wr_en) dest_o <= res_i.lo;
  end
endmodule // bcd_wb_model

// >>> tb/tb_top.sv
/*
  self-checking bench: apb register access, hand corners, random ops.
  assumes a 200 MHz clock and results one cycle after a request.
*/
`timescale 1ns/1ps
module tb_top;
  import bcd_pkg::*;
  logic clock_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, dest;
  bcd_req_t    req_i, r;
  bcd_res_t    res_o;
  bcd_flags_t  flags_o;
  int          err_total, comparisons, seed;
  bcd_datapath dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req_i), .unused_o_dummy_never(),
    .res_o(res_o), .flags_o(flags_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  bcd_wb_model wb (.clock_i(clock_i), .resetn_i(resetn_i), .res_i(res_o), .dest_o(dest));
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // leading count; sign mode starts one bit below the top
  function automatic logic [15:0] cnt(logic [31:0] x, int w, bit sg);
    int n;
    logic rf;
    n = 0;
    rf = sg & x[w-1];
    for (int i = w - 1 - sg; i >= 0; i--) begin
      if (x[i] != rf) break;
      n++;
    end
    return n[15:0];
  endfunction
  function automatic bcd_res_t expect_res(bcd_req_t q);
    bcd_res_t    e;
    logic [63:0] w;
    logic [31:0] m, d;
    logic        s;
    int          sh;
    e = '0;
    e.valid = 1'b1;
    e.wr_en = 1'b1;
    case (q.op)
      op_lead_sign: e.lo = {16'h0, cnt(q.opa, 32, 1)};
      op_lead_sign_half: e.lo = {cnt(q.opa >> 16, 16, 1), cnt(q.opa, 16, 1)};
      op_lead_zero: e.lo = {16'h0, cnt(q.opa, 32, 0)};
      op_lead_zero_half: e.lo = {cnt(q.opa >> 16, 16, 0), cnt(q.opa, 16, 0)};
      op_cond_move, op_cond_move_not: begin
        e.wr_en = (q.cond != 0) ^ (q.op == op_cond_move_not);
        e.lo = q.use_imm ? {{28{q.imm_four_bit[3]}}, q.imm_four_bit} : q.opb;
      end
      op_cond_sub, op_cond_sub_not: e.lo = ((q.cond != 0) ^ (q.op == op_cond_sub_not)) ? q.opa - q.opb : q.opa;
      op_dbl_extract: begin
        w = {q.opa, q.opb} << (q.use_imm ? q.imm_pos : q.cond[4:0]);
        e.lo = w[63:32];
      end
      op_div_adjust: begin
        m = q.cond[31] ? ~q.cond : q.cond;
        d = q.opb[31] ? -q.opb : q.opb;
        e.pair = 1'b1;
        if (q.cond[31] && m == d) {e.hi, e.lo} = {32'h0, q.opa + {31'h0, !q.opa[31]}};
        else {e.hi, e.lo} = {q.cond + {31'h0, q.cond[31]}, q.opa + {31'h0, q.opa[31]}};
      end
      default: begin
        s = q.op inside {op_div_setup_word, op_div_setup_byte, op_div_setup_half};
        sh = (q.op >= op_div_setup_half) ? 16 : (q.op >= op_div_setup_byte) ? 24 : 0;
        w = {{32{s & q.opa[31]}}, q.opa} << sh;
        if (s && (q.opa[31] ^ q.opb[31])) w = w | ((64'h1 << sh) - 64'h1);
        {e.hi, e.lo} = w;
        e.pair = 1'b1;
      end
    endcase
    return e;
  endfunction
  // ----------------------------------------------------------------
  // bus and request drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clock_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, dw};
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock_i);
    end
    if (n >= 50) err_total++;
    chk("apb", {31'h0, e}, {31'h0, pslverr_o, w ? e[31:0] : prdata_o});
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic send(input bcd_req_t q);
    bcd_res_t e;
    e = expect_res(q);
    q.valid = 1'b1;
    @(posedge clock_i);
    req_i <= q;
    @(posedge clock_i);
    req_i.valid <= 1'b0;
    #1;
    chk("valid_wr", {61'h0, 1'b1, e.wr_en, e.pair}, {61'h0, res_o.valid, res_o.wr_en, res_o.pair});
    chk(q.op.name(), {e.hi & {32{e.pair}}, e.lo & {32{e.wr_en}}},
      {res_o.hi & {32{e.pair}}, res_o.lo & {32{e.wr_en}}});
  endtask
  task automatic hand(input bcd_op_t o, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
    input logic u);
    r = '0;
    {r.op, r.opa, r.opb, r.cond, r.imm_four_bit, r.imm_pos, r.use_imm} = {o, a, b, c, 4'h9, 5'h1f, u};
    send(r);
  endtask
  function automatic bcd_req_t rnd(int i);
    bcd_req_t q;
    q.valid = 1'b0;
    q.op = bcd_op_t'(i[3:0]);
    q.opa = $random(seed);
    q.opb = i[5] ? q.opa : $random(seed);
    q.cond = i[4] ? $random(seed) : 32'h0;
    {q.imm_four_bit, q.imm_pos, q.use_imm} = 10'($random(seed));
    return q;
  endfunction
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, req_i} = '0;
    {err_total, comparisons, seed} = {32'h0, 32'h0, 32'd3928};
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    apb(0, REG_CTRL, 0, 33'h1);
    apb(0, REG_STATUS, 0, 33'h0);
    apb(0, 12'h010, 0, 33'h100000000);
    apb(1, 12'h010, 32'hffffffff, 33'h100000000);
    hand(op_lead_sign, 32'hffffffff, 0, 0, 0);
    hand(op_lead_sign, 32'h00000001, 0, 0, 0);
    hand(op_lead_zero, 32'h0, 0, 0, 0);
    hand(op_lead_sign_half, 32'h0001ffff, 0, 0, 0);
    hand(op_lead_zero_half, 32'h00008000, 0, 0, 0);
    hand(op_cond_move, 0, 32'h1234, 32'h5, 1);
    hand(op_cond_move, 0, 32'h1234, 32'h0, 0);
    chk("dest", 64'hfffffff9, {32'h0, dest});
    hand(op_cond_move_not, 0, 32'h1234, 32'h0, 0);
    hand(op_dbl_extract, 32'h80000001, 32'h80000001, 0, 1);
    hand(op_cond_sub, 32'h80000000, 32'h1, 32'h1, 0);
    chk("flags", 64'hf, {60'h0, flags_o});
    hand(op_cond_sub, 5, 1, 0, 0);
    hand(op_cond_sub_not, 5, 1, 7, 0);
    chk("flags", 64'hf, {60'h0, flags_o});
    hand(op_cond_sub_not, 5, 1, 0, 0);
    chk("flags", 64'h5, {60'h0, flags_o});
    apb(1, REG_STATUS, 32'ha, 33'h0);
    apb(0, REG_STATUS, 0, 33'h0);
    hand(op_div_setup_half, 32'hffff8000, 32'h3, 0, 0);
    hand(op_div_adjust, 32'hfffffffe, 32'h3, 32'hfffffffc, 0);
    hand(op_div_adjust, 32'hfffffffe, 32'hfffffffe, 32'h3, 0);
    apb(0, REG_LAST_LO, 0, 33'hffffffff);
    apb(0, REG_LAST_HI, 0, 33'h3);
    for (int i = 0; i < 256; i++) send(rnd(i));
    // back-to-back burst, judged by the bound checker
    for (int i = 0; i < 32; i++) begin
      r = rnd(i);
      r.valid = 1'b1;
      @(posedge clock_i);
      req_i <= r;
    end
    @(posedge clock_i);
    req_i.valid <= 1'b0;
    apb(1, REG_CTRL, 0, 33'h0);
    r.valid = 1'b1;
    @(posedge clock_i);
    req_i <= r;
    @(posedge clock_i);
    req_i.valid <= 1'b0;
    #1;
    chk("refused", 64'h0, {63'h0, res_o.valid});
    apb(1, REG_CTRL, 1, 33'h0);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    apb(0, REG_CTRL, 0, 33'h1);
    chk("flags", 64'h0, {60'h0, flags_o});
    final_report();
  end
endmodule // tb_top
bind bcd_datapath bcd_datapath_assertions u_chk (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req_i),
  .unused_o_dummy_never(unused_o_dummy_never), .res_o(res_o), .flags_o(flags_o), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
